// ---- rtl/rpps_top.sv ----
// Frame and pulse sequencer that duty-cycles the radar front-end enables.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module rpps_top #(
  parameter int unsigned FRAME_CYC = rpps_pkg::FRAME_CYC,
  parameter int unsigned PRT_CYC = rpps_pkg::PRT_CYC,
  parameter int unsigned BB_LEAD_CYC = rpps_pkg::BB_LEAD_CYC,
  parameter int unsigned TR_LEAD_CYC = rpps_pkg::TR_LEAD_CYC,
  parameter int unsigned BB_TAIL_CYC = rpps_pkg::BB_TAIL_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic transceiver_supply_enable,
  output logic transmit_path_enable,
  output logic temp_ref_supply_enable,
  output logic sample_hold_switch_control,
  output logic baseband_stage_enable,
  output logic sample_strobe,
  output logic sample_discard,
  output logic [15:0] sample_index
);
  localparam logic [31:0] BB_LEAD_W = 32'(BB_LEAD_CYC);
  localparam logic [31:0] TR_START_W = 32'(BB_LEAD_CYC - TR_LEAD_CYC);
  localparam logic [31:0] BB_TAIL_W = 32'(BB_TAIL_CYC);
  localparam logic [31:0] SH_START = rpps_pkg::SEG_A_CYC + rpps_pkg::SEG_B_CYC;

  typedef struct packed {
    rpps_pkg::rpps_fsm_t fsm;
    logic [31:0] frame_cnt;
    logic [31:0] prt_cnt;
    logic [15:0] pulse_idx;
    logic [31:0] tail_cnt;
    logic [31:0] frame_count;
    logic xcvr;
    logic tx;
    logic tr;
    logic sh;
    logic bb;
    logic strobe;
    logic discard;
    logic [15:0] index;
  } rpps_seq_t;

  rpps_seq_t seq_ff;
  rpps_seq_t nxt_seq;
  rpps_pkg::rpps_cfg_t cfg;
  rpps_pkg::rpps_stat_t stat;
  logic [31:0] sh_len;
  logic [16:0] total;
  logic train;

  function automatic logic in_win(input logic [31:0] v, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_win = (v >= lo) && (v < hi);
  endfunction : in_win

  rpps_apb_regs #(
    .FRAME_CYC(FRAME_CYC),
    .PRT_CYC(PRT_CYC)
  ) u_regs (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .stat(stat),
    .cfg(cfg)
  );

  assign stat = '{fsm: seq_ff.fsm, frame_count: seq_ff.frame_count};

  always_comb begin
    // Only the sample-and-hold segment stretches with the pulse width.
    sh_len = (cfg.pulse_width > rpps_pkg::SEG_FIX_CYC) ?
             cfg.pulse_width - rpps_pkg::SEG_FIX_CYC : 32'h0000_0001;
    total = {1'b0, cfg.n_samples} + {1'b0, cfg.n_skip};
    train = seq_ff.fsm == rpps_pkg::RPPS_TRAIN;
    nxt_seq = seq_ff;
    // Enables are decoded from the present state and registered.
    nxt_seq.xcvr = train && (seq_ff.prt_cnt < rpps_pkg::SEG_FIX_CYC + sh_len);
    nxt_seq.tx = train && in_win(seq_ff.prt_cnt, rpps_pkg::SEG_A_CYC,
                                 SH_START + sh_len + rpps_pkg::SEG_D_CYC);
    nxt_seq.sh = train && in_win(seq_ff.prt_cnt, SH_START, SH_START + sh_len);
    nxt_seq.tr = (seq_ff.fsm == rpps_pkg::RPPS_LEAD &&
                  in_win(seq_ff.frame_cnt, TR_START_W, BB_LEAD_W)) ||
                 (train && seq_ff.prt_cnt < cfg.tr_width);
    nxt_seq.bb = seq_ff.fsm == rpps_pkg::RPPS_LEAD || train ||
                 (seq_ff.fsm == rpps_pkg::RPPS_OFF && seq_ff.tail_cnt != 32'h0000_0000);
    nxt_seq.strobe = train && seq_ff.prt_cnt == SH_START + sh_len;
    if (train && seq_ff.prt_cnt == SH_START + sh_len) begin
      nxt_seq.discard = seq_ff.pulse_idx < cfg.n_skip;
      nxt_seq.index = seq_ff.pulse_idx;
    end
    case (seq_ff.fsm)
      rpps_pkg::RPPS_IDLE: begin
        nxt_seq.frame_cnt = 32'h0000_0000;
        if (cfg.enable) begin
          nxt_seq.fsm = rpps_pkg::RPPS_LEAD;
        end
      end
      rpps_pkg::RPPS_LEAD: begin
        nxt_seq.frame_cnt = seq_ff.frame_cnt + 32'h0000_0001;
        if (seq_ff.frame_cnt == BB_LEAD_W - 32'h0000_0001) begin
          nxt_seq.fsm = rpps_pkg::RPPS_TRAIN;
          nxt_seq.prt_cnt = 32'h0000_0000;
          nxt_seq.pulse_idx = 16'h0000;
        end
      end
      rpps_pkg::RPPS_TRAIN: begin
        nxt_seq.frame_cnt = seq_ff.frame_cnt + 32'h0000_0001;
        nxt_seq.prt_cnt = seq_ff.prt_cnt + 32'h0000_0001;
        if (seq_ff.prt_cnt >= cfg.prt - 32'h0000_0001) begin
          nxt_seq.prt_cnt = 32'h0000_0000;
          if ({1'b0, seq_ff.pulse_idx} == total - 17'h0_0001) begin
            nxt_seq.fsm = rpps_pkg::RPPS_OFF;
            nxt_seq.tail_cnt = BB_TAIL_W;
          end else begin
            nxt_seq.pulse_idx = seq_ff.pulse_idx + 16'h0001;
          end
        end
      end
      rpps_pkg::RPPS_OFF: begin
        nxt_seq.frame_cnt = seq_ff.frame_cnt + 32'h0000_0001;
        if (seq_ff.tail_cnt != 32'h0000_0000) begin
          nxt_seq.tail_cnt = seq_ff.tail_cnt - 32'h0000_0001;
        end
      end
      default: nxt_seq.fsm = rpps_pkg::RPPS_IDLE;
    endcase
    // The frame end restarts the next frame whatever the phase.
    if (seq_ff.fsm != rpps_pkg::RPPS_IDLE &&
        seq_ff.frame_cnt >= cfg.frame_time - 32'h0000_0001) begin
      nxt_seq.fsm = rpps_pkg::RPPS_LEAD;
      nxt_seq.frame_cnt = 32'h0000_0000;
      nxt_seq.tail_cnt = 32'h0000_0000;
      nxt_seq.frame_count = seq_ff.frame_count + 32'h0000_0001;
    end
    if (!cfg.enable) begin
      nxt_seq.fsm = rpps_pkg::RPPS_IDLE;
      nxt_seq.frame_cnt = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      seq_ff <= '0;
    end else if (ce) begin
      seq_ff <= nxt_seq;
    end
  end

  assign transceiver_supply_enable = seq_ff.xcvr;
  assign transmit_path_enable = seq_ff.tx;
  assign temp_ref_supply_enable = seq_ff.tr;
  assign sample_hold_switch_control = seq_ff.sh;
  assign baseband_stage_enable = seq_ff.bb;
  assign sample_strobe = seq_ff.strobe;
  assign sample_discard = seq_ff.discard;
  assign sample_index = seq_ff.index;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  xcvr_off_a: assert property (
    ce && seq_ff.fsm != rpps_pkg::RPPS_TRAIN |=> !transceiver_supply_enable)
    else $error("Transceiver supply on outside the pulse train.");
  xcvr_width_a: assert property (
    ce && train && seq_ff.prt_cnt == rpps_pkg::SEG_FIX_CYC + sh_len - 32'h0000_0001
    |=> transceiver_supply_enable ##1 (!$past(ce) || !transceiver_supply_enable))
    else $error("Transceiver supply width differs from the pulse width.");
  tr_lead_a: assert property (
    ce && seq_ff.fsm == rpps_pkg::RPPS_LEAD && seq_ff.frame_cnt == TR_START_W
    |=> temp_ref_supply_enable)
    else $error("Temperature reference not on at its lead time.");
  tr_pulse_a: assert property (
    ce && train && seq_ff.prt_cnt >= cfg.tr_width |=> !temp_ref_supply_enable)
    else $error("Temperature reference pulse too long.");
  bb_lead_a: assert property (
    ce && seq_ff.fsm == rpps_pkg::RPPS_LEAD |=> baseband_stage_enable)
    else $error("Baseband stage off during the lead.");
  sh_edge_a: assert property (
    ce && train && seq_ff.prt_cnt == SH_START |=> sample_hold_switch_control
    && transmit_path_enable && transceiver_supply_enable)
    else $error("Sample-and-hold did not close at its fixed offset.");
  skip_flag_a: assert property (
    sample_strobe |-> sample_discard == (sample_index < cfg.n_skip) ||
    $changed(cfg.n_skip))
    else $error("Skipped sample not flagged as discarded.");
  frame_wrap_a: assert property (
    ce && cfg.enable && seq_ff.fsm != rpps_pkg::RPPS_IDLE &&
    seq_ff.frame_cnt == cfg.frame_time - 32'h0000_0001
    |=> seq_ff.fsm == rpps_pkg::RPPS_LEAD && seq_ff.frame_cnt == 32'h0000_0000)
    else $error("Frame did not restart at the frame time.");
  reset_off_a: assert property (disable iff (1'b0)
    srst |=> !transceiver_supply_enable && !temp_ref_supply_enable &&
    !baseband_stage_enable && seq_ff.frame_count == 32'h0000_0000)
    else $error("Enables or frame counter not cleared by reset.");
  reset_cfg_a: assert property (disable iff (1'b0)
    srst |=> cfg.frame_time == 32'(FRAME_CYC) && cfg.n_samples == 16'h0080 &&
    cfg.n_skip == 16'h0028)
    else $error("Default frame settings wrong after reset.");
endmodule : rpps_top

// ---- rtl/rpps_pkg.sv ----
// Constants and carrier types of the radar pulse power sequencer.
package rpps_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned FRAME_MS = 150;
  localparam int unsigned BB_LEAD_MS = 20;
  localparam int unsigned TR_LEAD_MS = 1;
  localparam int unsigned BB_TAIL_US = 1000;
  localparam int unsigned PRT_US = 500;
  localparam int unsigned XCVR_PW_NS = 5000;
  localparam int unsigned TR_PW_NS = 20000;
  localparam int unsigned SEG_A_NS = 1000;
  localparam int unsigned SEG_B_NS = 500;
  localparam int unsigned SEG_D_NS = 200;
  localparam int unsigned SEG_E_NS = 200;
  localparam int unsigned FRAME_CYC = FRAME_MS * 1000 * CLK_MHZ;
  localparam int unsigned BB_LEAD_CYC = BB_LEAD_MS * 1000 * CLK_MHZ;
  localparam int unsigned TR_LEAD_CYC = TR_LEAD_MS * 1000 * CLK_MHZ;
  localparam int unsigned BB_TAIL_CYC = BB_TAIL_US * CLK_MHZ;
  localparam int unsigned PRT_CYC = PRT_US * CLK_MHZ;
  localparam logic [31:0] XCVR_PW_CYC = 32'((XCVR_PW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [31:0] TR_PW_CYC = 32'((TR_PW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [31:0] SEG_A_CYC = 32'((SEG_A_NS * CLK_MHZ + 999) / 1000);
  localparam logic [31:0] SEG_B_CYC = 32'((SEG_B_NS * CLK_MHZ + 999) / 1000);
  localparam logic [31:0] SEG_D_CYC = 32'((SEG_D_NS * CLK_MHZ + 999) / 1000);
  localparam logic [31:0] SEG_E_CYC = 32'((SEG_E_NS * CLK_MHZ + 999) / 1000);
  localparam logic [31:0] SEG_FIX_CYC = SEG_A_CYC + SEG_B_CYC + SEG_D_CYC + SEG_E_CYC;
  localparam logic [15:0] N_SAMPLES_RST = 16'h0080;
  localparam logic [15:0] N_SKIP_RST = 16'h0028;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FRAME = 8'h04;
  localparam logic [7:0] OFS_NSAMP = 8'h08;
  localparam logic [7:0] OFS_NSKIP = 8'h0C;
  localparam logic [7:0] OFS_PW = 8'h10;
  localparam logic [7:0] OFS_PRT = 8'h14;
  localparam logic [7:0] OFS_TRPW = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_FCOUNT = 8'h20;
  typedef enum logic [1:0] {
    RPPS_IDLE = 2'h0,
    RPPS_LEAD = 2'h1,
    RPPS_TRAIN = 2'h3,
    RPPS_OFF = 2'h2
  } rpps_fsm_t;
  typedef struct packed {
    logic enable;
    logic [31:0] frame_time;
    logic [15:0] n_samples;
    logic [15:0] n_skip;
    logic [31:0] pulse_width;
    logic [31:0] prt;
    logic [31:0] tr_width;
  } rpps_cfg_t;
  typedef struct packed {
    rpps_fsm_t fsm;
    logic [31:0] frame_count;
  } rpps_stat_t;
endpackage : rpps_pkg

// ---- rtl/rpps_apb_regs.sv ----
// APB register file of the radar pulse power sequencer.
`timescale 1ns/100ps
module rpps_apb_regs #(
  parameter int unsigned FRAME_CYC = rpps_pkg::FRAME_CYC,
  parameter int unsigned PRT_CYC = rpps_pkg::PRT_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rpps_pkg::rpps_stat_t stat,
  output rpps_pkg::rpps_cfg_t cfg
);
  typedef struct packed {
    rpps_pkg::rpps_cfg_t cfg;
    logic [31:0] rdata;
    logic err;
    logic rdy;
  } rpps_regs_t;

  localparam rpps_regs_t REGS_RST = '{
    cfg: '{
      enable: 1'b0,
      frame_time: 32'(FRAME_CYC),
      n_samples: rpps_pkg::N_SAMPLES_RST,
      n_skip: rpps_pkg::N_SKIP_RST,
      pulse_width: rpps_pkg::XCVR_PW_CYC,
      prt: 32'(PRT_CYC),
      tr_width: rpps_pkg::TR_PW_CYC
    },
    rdata: 32'h0000_0000,
    err: 1'b0,
    rdy: 1'b0
  };

  rpps_regs_t regs_ff;
  rpps_regs_t nxt_regs;

  // Read data and the error answer are captured in the setup cycle.
  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.rdy = psel && !regs_ff.rdy;
    if (psel && !regs_ff.rdy) begin
      nxt_regs.err = 1'b0;
      case (paddr)
        rpps_pkg::OFS_CTRL: nxt_regs.rdata = {31'h0000_0000, regs_ff.cfg.enable};
        rpps_pkg::OFS_FRAME: nxt_regs.rdata = regs_ff.cfg.frame_time;
        rpps_pkg::OFS_NSAMP: nxt_regs.rdata = {16'h0000, regs_ff.cfg.n_samples};
        rpps_pkg::OFS_NSKIP: nxt_regs.rdata = {16'h0000, regs_ff.cfg.n_skip};
        rpps_pkg::OFS_PW: nxt_regs.rdata = regs_ff.cfg.pulse_width;
        rpps_pkg::OFS_PRT: nxt_regs.rdata = regs_ff.cfg.prt;
        rpps_pkg::OFS_TRPW: nxt_regs.rdata = regs_ff.cfg.tr_width;
        rpps_pkg::OFS_STATUS: nxt_regs.rdata = {30'h0000_0000, stat.fsm};
        rpps_pkg::OFS_FCOUNT: nxt_regs.rdata = stat.frame_count;
        default: begin
          nxt_regs.rdata = 32'h0000_0000;
          nxt_regs.err = 1'b1;
        end
      endcase
    end
    if (psel && penable && regs_ff.rdy && pwrite) begin
      case (paddr)
        rpps_pkg::OFS_CTRL: nxt_regs.cfg.enable = pwdata[0];
        rpps_pkg::OFS_FRAME: nxt_regs.cfg.frame_time = pwdata;
        rpps_pkg::OFS_NSAMP: nxt_regs.cfg.n_samples = pwdata[15:0];
        rpps_pkg::OFS_NSKIP: nxt_regs.cfg.n_skip = pwdata[15:0];
        rpps_pkg::OFS_PW: nxt_regs.cfg.pulse_width = pwdata;
        rpps_pkg::OFS_PRT: nxt_regs.cfg.prt = pwdata;
        rpps_pkg::OFS_TRPW: nxt_regs.cfg.tr_width = pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regs_ff <= REGS_RST;
    end else if (ce) begin
      regs_ff <= nxt_regs;
    end
  end

  assign pready = regs_ff.rdy && ce;
  assign prdata = regs_ff.rdata;
  assign pslverr = regs_ff.err;
  assign cfg = regs_ff.cfg;
endmodule : rpps_apb_regs

// ---- verification/rpps_front_end.sv ----
// Front-end load model that measures the transceiver supply and temperature reference enable pulse lengths.
`timescale 1ns/100ps
module rpps_front_end (
  input wire logic clk_sys,
  input wire logic transceiver_supply_enable,
  input wire logic temp_ref_supply_enable,
  output logic [31:0] supply_width,
  output logic [31:0] tr_width
);
  logic [31:0] sup_run = 32'h0;
  logic [31:0] tr_run = 32'h0;
  initial supply_width = 32'h0;
  initial tr_width = 32'h0;
  // Each run length is latched when the enable falls, so only complete pulses are reported.
  always @(posedge clk_sys) begin
    if (transceiver_supply_enable === 1'b1) begin
      sup_run <= sup_run + 32'h1;
    end else if (sup_run != 32'h0) begin
      supply_width <= sup_run;
      sup_run <= 32'h0;
    end
    if (temp_ref_supply_enable === 1'b1) begin
      tr_run <= tr_run + 32'h1;
    end else if (tr_run != 32'h0) begin
      tr_width <= tr_run;
      tr_run <= 32'h0;
    end
  end
endmodule : rpps_front_end

// ---- verification/testbench.sv ----
// Self-checking bench of the radar pulse power sequencer with a cycle model.
`timescale 1ns/100ps
module testbench;
  localparam int FRM = 2000;
  localparam int PRT = 100;
  localparam int BBL = 200;
  localparam int TRL = 50;
  localparam int BBT = 20;
  localparam int A = int'(rpps_pkg::SEG_A_CYC);
  localparam int B = int'(rpps_pkg::SEG_B_CYC);
  localparam int D = int'(rpps_pkg::SEG_D_CYC);
  localparam int FIX = int'(rpps_pkg::SEG_FIX_CYC);
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, sup_w, tr_w, q;
  logic pready, pslverr, sup, tx, trf, shc, bb, stb, dis, e;
  logic [15:0] sidx;
  logic [5:0] ex = 6'h00;
  int fails = 0;
  int n_compared = 0;
  int fr = FRM, prt = PRT, pw = 625, trw = 2500, ns = 128, nk = 40;
  int en = 0, mt = -1, mfc = 0, ek = 0;
  rpps_top #(.FRAME_CYC(FRM), .PRT_CYC(PRT), .BB_LEAD_CYC(BBL), .TR_LEAD_CYC(TRL),
    .BB_TAIL_CYC(BBT)) dut_u (.clk_sys(clk_sys), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .transceiver_supply_enable(sup),
    .transmit_path_enable(tx), .temp_ref_supply_enable(trf),
    .sample_hold_switch_control(shc), .baseband_stage_enable(bb), .sample_strobe(stb),
    .sample_discard(dis), .sample_index(sidx));
  rpps_front_end fe_u (.clk_sys(clk_sys), .transceiver_supply_enable(sup),
    .temp_ref_supply_enable(trf), .supply_width(sup_w), .tr_width(tr_w));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // Cycle model: predicts the outputs after each edge from the frame position before it.
  // A low clock enable freezes the model just as it freezes the design.
  always @(posedge clk_sys) if (srst || ce) begin
    int sh, u, p, te;
    sh = (pw > FIX) ? pw - FIX : 1;
    u = mt - BBL;
    p = (u < 0) ? 0 : u % prt;
    te = BBL + (ns + nk) * prt;
    if (mt < 0) ex = 6'h00;
    else if (mt < BBL) ex = {2'b00, mt >= BBL - TRL, 1'b0, 1'b1, 1'b0};
    else if (mt < te) ex = {p < FIX + sh, p >= A && p < A + B + sh + D, p < trw,
      p >= A + B && p < A + B + sh, 1'b1, p == A + B + sh};
    else ex = {4'h0, mt < te + BBT, 1'b0};
    if (ex[0]) ek = u / prt;
    if (srst || en == 0) begin
      mt = -1;
      if (srst) mfc = 0;
    end else if (mt < 0) begin
      mt = 0;
    end else if (mt + 1 >= fr) begin
      mt = 0;
      mfc++;
    end else begin
      mt++;
    end
    if (srst) begin
      en = 0;
    end else if (psel && penable && pready === 1'b1 && pwrite) begin
      case (paddr)
        rpps_pkg::OFS_CTRL: en = int'(pwdata[0]);
        rpps_pkg::OFS_FRAME: fr = int'(pwdata);
        rpps_pkg::OFS_NSAMP: ns = int'(pwdata[15:0]);
        rpps_pkg::OFS_NSKIP: nk = int'(pwdata[15:0]);
        rpps_pkg::OFS_PW: pw = int'(pwdata);
        rpps_pkg::OFS_PRT: prt = int'(pwdata);
        rpps_pkg::OFS_TRPW: trw = int'(pwdata);
        default: en = en;
      endcase
    end
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", nm, x, g);
    end
  endtask : chk
  always @(negedge clk_sys) begin
    if (!srst) begin
      chk("enables", {26'h0, ex}, {26'h0, sup, tx, trf, shc, bb, stb});
      if (ex[0]) chk("index", ek, {16'h0, sidx});
      if (ex[0]) chk("discard", {31'h0, ek < nk}, {31'h0, dis});
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("unexpected pready expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("write error", 32'h0, {31'h0, e});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read data", x, q);
  endtask : rd
  task automatic results;
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    $display("unexpected run time expected finished seen timeout");
    results();
  end
  initial begin
    int pwl[3];
    int t;
    void'($urandom(63462));
    pwl[0] = 200;
    pwl[1] = 239 + int'($urandom % 92);
    pwl[2] = 239 + int'($urandom % 92);
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(rpps_pkg::OFS_NSAMP, 32'h00000080);
    rd(rpps_pkg::OFS_NSKIP, 32'h00000028);
    rd(rpps_pkg::OFS_PW, rpps_pkg::XCVR_PW_CYC);
    rd(rpps_pkg::OFS_TRPW, rpps_pkg::TR_PW_CYC);
    rd(rpps_pkg::OFS_FCOUNT, 32'h00000000);
    rd(rpps_pkg::OFS_STATUS, 32'h00000000);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b1, 8'h02, 32'h1);
    chk("misaligned error", 32'h1, {31'h0, e});
    wr(rpps_pkg::OFS_FRAME, 32'h00000BB8);
    wr(rpps_pkg::OFS_PRT, 32'h00000190);
    wr(rpps_pkg::OFS_NSAMP, 32'h00000004);
    wr(rpps_pkg::OFS_NSKIP, 32'h00000002);
    rd(rpps_pkg::OFS_FRAME, 32'h00000BB8);
    for (int i = 0; i < 3; i++) begin
      t = 1 + int'($urandom % 60);
      wr(rpps_pkg::OFS_PW, 32'(pwl[i]));
      wr(rpps_pkg::OFS_TRPW, 32'(t));
      wr(rpps_pkg::OFS_CTRL, 32'h00000001);
      repeat (6950) @(posedge clk_sys);
      // The pause falls in the quiet tail of a pulse, so measured widths stay whole.
      ce <= 1'b0;
      repeat (1 + int'($urandom % 8)) @(posedge clk_sys);
      ce <= 1'b1;
      repeat (50) @(posedge clk_sys);
      rd(rpps_pkg::OFS_FCOUNT, 32'(mfc));
      rd(rpps_pkg::OFS_STATUS, 32'h00000003);
      chk("supply width", 32'(FIX + ((pwl[i] > FIX) ? pwl[i] - FIX : 1)), sup_w);
      chk("reference width", 32'(t), tr_w);
      wr(rpps_pkg::OFS_CTRL, 32'h00000000);
      repeat (10) @(posedge clk_sys);
    end
    results();
  end
endmodule : testbench
